//--- spio_pkg.sv
/*
  Shared constants and types for the sequencer playback and port unit.
  Assumes a single 100 MHz clock; every other rate is derived from it.
*/
`default_nettype none
package spio_pkg;

  localparam int WORD_W = 32;
  localparam int CLK_MHZ = 100;
  localparam int PORT_RATE_MHZ = 50;
  localparam int PACE_CYCLES = (CLK_MHZ + PORT_RATE_MHZ - 1) / PORT_RATE_MHZ;
  localparam logic [33:0] DELAY_OVERHEAD = 34'h000000003;
  localparam int TRIG_OUT_N = 4;
  localparam int TRIG_IN_N = 8;
  localparam int FRAC_BITS = 16;

  // Field positions inside the second instruction operand.
  localparam int ARG_COUNT_LSB = 0;
  localparam int ARG_RATE_LSB = 4;
  localparam int ARG_RATE_GIVEN = 8;
  localparam int ARG_ADDR_LSB = 0;
  localparam int ARG_DEV_LSB = 16;

  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [7:0] SELF_DEVICE = 8'h00;
  localparam logic [3:0] MAX_WAVES = 4'h8;

  localparam logic [1:0] SLOPE_RISE = 2'h1;
  localparam logic [1:0] SLOPE_FALL = 2'h2;
  localparam logic [1:0] SLOPE_BOTH = 2'h3;

  typedef enum logic [3:0] {
    OP_NOP, OP_PORT_WRITE, OP_PORT_READ, OP_PORT_LATCHED_READ, OP_TRIG_OUT, OP_DELAY,
    OP_STROBE_WAIT, OP_TRIG_IN_READ, OP_INDEX_SET, OP_INDEX_ALIAS, OP_PLAY_DONE_WAIT,
    OP_PLAY, OP_SYNC, OP_NODE_INT, OP_NODE_FLOAT, OP_NODE_FLOAT_SCALED
  } spio_op_t;

endpackage : spio_pkg
`default_nettype wire

//--- spio_strobe_if.sv
/*
  Carrier between the executer and its port strobe detector.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface spio_strobe_if;
  logic [31:0] port_word;
  logic [4:0] strobe_idx;
  logic [1:0] strobe_slope;
  logic strobe_event;
  logic [31:0] latched_word;

  modport detector (input port_word, input strobe_idx, input strobe_slope,
                    output strobe_event, output latched_word);
  modport user (output port_word, output strobe_idx, output strobe_slope,
                input strobe_event, input latched_word);
endinterface : spio_strobe_if
`default_nettype wire

//--- spio_pace.sv
/*
  Divider giving a one-cycle enable at the parallel port update rate.
  Assumes the 100 MHz system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module spio_pace
  import spio_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  output logic tick
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic next_tick;

  always_comb begin
    next_tick = (cnt == 4'(PACE_CYCLES - 1));
    next_cnt = next_tick ? 4'h0 : cnt + 4'h1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : spio_pace
`default_nettype wire

//--- spio_strobe.sv
/*
  Port strobe detector: finds the configured edge on the configured port bit
  and latches the whole port word at that moment.
  Assumes the port word is already synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module spio_strobe
  import spio_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  spio_strobe_if.detector sif
);
  logic prev_bit;
  logic next_prev_bit;
  logic [31:0] next_latched;
  logic next_event;
  logic cur_bit;

  always_comb begin
    cur_bit = sif.port_word[sif.strobe_idx];
    next_prev_bit = cur_bit;
    next_event = 1'b0;
    case (sif.strobe_slope)
      SLOPE_RISE: next_event = cur_bit && !prev_bit;
      SLOPE_FALL: next_event = !cur_bit && prev_bit;
      SLOPE_BOTH: next_event = cur_bit != prev_bit;
      default: next_event = 1'b0;
    endcase
    next_latched = next_event ? sif.port_word : sif.latched_word;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_bit <= 1'b0;
      sif.strobe_event <= 1'b0;
      sif.latched_word <= RST_WORD;
    end else begin
      prev_bit <= next_prev_bit;
      sif.strobe_event <= next_event;
      sif.latched_word <= next_latched;
    end
  end
endmodule : spio_strobe
`default_nettype wire

//--- spio_exec.sv
/*
  Instruction executer of the waveform sequencer: port, trigger, delay, wait,
  index, playback queue, sync and node write instructions.
  Assumes instructions arrive in program order on a valid/ready port, and that
  the waveform engine, sync partner and node bus answer with their own pulses.
*/
// Behaviour
// - port write drives full 32-bit word
// - port updates paced at 50 MHz
// - port read returns live 32-bit word
// - latched read returns word at strobe
// - trigger write sets four lines together
// - delay stalls operand clock cycles
// - delay adds three cycle overhead
// - strobe wait on configured bit, edge
// - trigger read returns selected input 1-8
// - index set and alias load stream index
// - playback wait until playback finished
// - play queued, starts gaplessly after previous
// - no channels given maps by count
// - missing rate uses default rate
// - sync point with linked instruments
// - node write, empty device means self
// - scaled float write multiplies before commit
`timescale 1ns/10ps
`default_nettype none
module spio_exec
  import spio_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire spio_op_t instr_op,
  input wire logic [31:0] instr_value,
  input wire logic [31:0] instr_arg,
  input wire logic [31:0] instr_scale,
  input wire logic [7:0] instr_sel,
  output logic result_valid,
  output logic [31:0] result_data,
  input wire logic [31:0] port_in,
  output logic [31:0] port_out,
  output logic port_oe_n,
  input wire logic cfg_port_drive,
  input wire logic [4:0] cfg_strobe_idx,
  input wire logic [1:0] cfg_strobe_slope,
  output logic [3:0] trig_out,
  input wire logic [7:0] trig_in,
  input wire logic [7:0] trig_alt,
  input wire logic [7:0] cfg_trig_src,
  output logic [31:0] stream_index,
  input wire logic [3:0] default_sample_rate,
  output logic play_start,
  output logic [15:0] play_wave_id,
  output logic [7:0] play_channels,
  output logic [3:0] play_rate,
  input wire logic wave_done,
  input wire logic cfg_sync_linked,
  output logic sync_req,
  input wire logic sync_ack,
  input wire logic [7:0] self_device,
  output logic node_wr_valid,
  input wire logic node_wr_ready,
  output logic [7:0] node_dev,
  output logic [15:0] node_addr,
  output logic [31:0] node_data
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_DELAY, ST_PORT_WR, ST_STROBE, ST_PLAY_Q, ST_PLAY_WAIT, ST_SYNC, ST_NODE
  } spio_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  spio_strobe_if sif ();
  logic pace_tick;

  spio_pace u_pace (
    .clk(clk),
    .rstn(rstn),
    .tick(pace_tick)
  );

  spio_strobe u_strobe (
    .clk(clk),
    .rstn(rstn),
    .sif(sif)
  );

  assign sif.port_word = port_in;
  assign sif.strobe_idx = cfg_strobe_idx;
  assign sif.strobe_slope = cfg_strobe_slope;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer state.

  spio_state_t state, next_state;
  logic [33:0] cnt, next_cnt;
  logic [31:0] hold, next_hold;
  logic [7:0] hold_chan, next_hold_chan;
  logic [3:0] hold_rate, next_hold_rate;
  logic next_ready, next_result_valid;
  logic [31:0] next_result_data, next_port_out, next_stream_index;
  logic [3:0] next_trig_out;
  logic next_sync_req, next_node_wr_valid;
  logic [7:0] next_node_dev;
  logic [15:0] next_node_addr;
  logic [31:0] next_node_data;
  logic [7:0] play_chan_req;
  logic [3:0] play_rate_req, wave_count;
  logic [63:0] scaled;
  logic [3:0] trig_idx;
  logic accept, queue_free;

  // Playback queue: one pending entry behind the waveform that is playing.
  logic pend, next_pend, playing, next_playing;
  logic [15:0] pend_wave, next_pend_wave;
  logic [7:0] pend_chan, next_pend_chan;
  logic [3:0] pend_rate, next_pend_rate;
  logic launch, enq;
  logic next_play_start;
  logic [15:0] next_play_wave_id;
  logic [7:0] next_play_channels;
  logic [3:0] next_play_rate;

  always_comb begin
    accept = instr_valid && instr_ready;
    wave_count = instr_arg[ARG_COUNT_LSB +: 4];
    if (wave_count == 4'h0) begin
      wave_count = 4'h1;
    end else if (wave_count > MAX_WAVES) begin
      wave_count = MAX_WAVES;
    end
    // With no explicit channels, the lowest channels are filled in order.
    play_chan_req = (instr_sel != 8'h00) ? instr_sel : 8'((9'h001 << wave_count) - 9'h001);
    play_rate_req = instr_arg[ARG_RATE_GIVEN] ? instr_arg[ARG_RATE_LSB +: 4] : default_sample_rate;
    scaled = 64'($signed(instr_value) * $signed(instr_scale));
    trig_idx = instr_sel[3:0] - 4'h1;
    queue_free = !pend || launch;
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_hold = hold;
    next_hold_chan = hold_chan;
    next_hold_rate = hold_rate;
    next_result_valid = 1'b0;
    next_result_data = result_data;
    next_port_out = port_out;
    next_trig_out = trig_out;
    next_stream_index = stream_index;
    next_sync_req = sync_req;
    next_node_wr_valid = node_wr_valid;
    next_node_dev = node_dev;
    next_node_addr = node_addr;
    next_node_data = node_data;
    enq = 1'b0;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          case (instr_op)
            OP_PORT_WRITE: begin
              next_hold = instr_value;
              next_state = ST_PORT_WR;
            end
            OP_PORT_READ: begin
              next_result_data = port_in;
              next_result_valid = 1'b1;
            end
            OP_PORT_LATCHED_READ: begin
              next_result_data = sif.latched_word;
              next_result_valid = 1'b1;
            end
            OP_TRIG_OUT: next_trig_out = instr_value[TRIG_OUT_N-1:0];
            OP_DELAY: begin
              // Busy for operand plus two cycles; the accept cycle makes the third.
              next_cnt = {2'b00, instr_value} + DELAY_OVERHEAD - 34'h000000001;
              next_state = ST_DELAY;
            end
            OP_STROBE_WAIT: next_state = ST_STROBE;
            OP_TRIG_IN_READ: begin
              next_result_valid = 1'b1;
              next_result_data = RST_WORD;
              if (instr_sel >= 8'h01 && instr_sel <= 8'(TRIG_IN_N)) begin
                next_result_data[0] = cfg_trig_src[trig_idx[2:0]] ? trig_alt[trig_idx[2:0]]
                                                                  : trig_in[trig_idx[2:0]];
              end
            end
            OP_INDEX_SET, OP_INDEX_ALIAS: next_stream_index = instr_value;
            OP_PLAY_DONE_WAIT: next_state = ST_PLAY_WAIT;
            OP_PLAY: begin
              next_hold = {16'h0000, instr_value[15:0]};
              next_hold_chan = play_chan_req;
              next_hold_rate = play_rate_req;
              if (queue_free) begin
                enq = 1'b1;
              end else begin
                next_state = ST_PLAY_Q;
              end
            end
            OP_SYNC: begin
              // Without linked instruments the sync point is a no-op.
              if (cfg_sync_linked) begin
                next_sync_req = 1'b1;
                next_state = ST_SYNC;
              end
            end
            OP_NODE_INT, OP_NODE_FLOAT, OP_NODE_FLOAT_SCALED: begin
              next_node_addr = instr_arg[ARG_ADDR_LSB +: 16];
              next_node_dev = (instr_arg[ARG_DEV_LSB +: 8] == SELF_DEVICE) ? self_device
                                                                           : instr_arg[ARG_DEV_LSB +: 8];
              next_node_data = (instr_op == OP_NODE_FLOAT_SCALED) ? scaled[FRAC_BITS +: 32] : instr_value;
              next_node_wr_valid = 1'b1;
              next_state = ST_NODE;
            end
            default: next_state = ST_IDLE;
          endcase
        end
      end
      ST_DELAY: begin
        next_cnt = cnt - 34'h000000001;
        if (cnt == 34'h000000001) begin
          next_state = ST_IDLE;
        end
      end
      ST_PORT_WR: begin
        // Waiting for the pace tick keeps writes at the port's own rate.
        if (pace_tick) begin
          next_port_out = hold;
          next_state = ST_IDLE;
        end
      end
      ST_STROBE: begin
        if (sif.strobe_event) begin
          next_state = ST_IDLE;
        end
      end
      ST_PLAY_Q: begin
        if (queue_free) begin
          enq = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_PLAY_WAIT: begin
        if (!pend && (!playing || wave_done)) begin
          next_state = ST_IDLE;
        end
      end
      ST_SYNC: begin
        if (sync_ack) begin
          next_sync_req = 1'b0;
          next_state = ST_IDLE;
        end
      end
      ST_NODE: begin
        if (node_wr_ready) begin
          next_node_wr_valid = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_ready = (next_state == ST_IDLE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cnt <= 34'h000000000;
      hold <= RST_WORD;
      hold_chan <= 8'h00;
      hold_rate <= 4'h0;
      instr_ready <= 1'b0;
      result_valid <= 1'b0;
      result_data <= RST_WORD;
      port_out <= RST_WORD;
      trig_out <= 4'h0;
      stream_index <= RST_WORD;
      sync_req <= 1'b0;
      node_wr_valid <= 1'b0;
      node_dev <= 8'h00;
      node_addr <= 16'h0000;
      node_data <= RST_WORD;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      hold <= next_hold;
      hold_chan <= next_hold_chan;
      hold_rate <= next_hold_rate;
      instr_ready <= next_ready;
      result_valid <= next_result_valid;
      result_data <= next_result_data;
      port_out <= next_port_out;
      trig_out <= next_trig_out;
      stream_index <= next_stream_index;
      sync_req <= next_sync_req;
      node_wr_valid <= next_node_wr_valid;
      node_dev <= next_node_dev;
      node_addr <= next_node_addr;
      node_data <= next_node_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Playback queue and launcher.

  always_comb begin
    // Launching in the same cycle as the done pulse leaves no gap between waveforms.
    launch = pend && (!playing || wave_done);
    next_pend = pend;
    next_pend_wave = pend_wave;
    next_pend_chan = pend_chan;
    next_pend_rate = pend_rate;
    if (launch) begin
      next_pend = 1'b0;
    end
    if (enq) begin
      next_pend = 1'b1;
      next_pend_wave = (state == ST_IDLE) ? instr_value[15:0] : hold[15:0];
      next_pend_chan = (state == ST_IDLE) ? play_chan_req : hold_chan;
      next_pend_rate = (state == ST_IDLE) ? play_rate_req : hold_rate;
    end
    next_playing = launch ? 1'b1 : (wave_done ? 1'b0 : playing);
    next_play_start = launch;
    next_play_wave_id = launch ? pend_wave : play_wave_id;
    next_play_channels = launch ? pend_chan : play_channels;
    next_play_rate = launch ? pend_rate : play_rate;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend <= 1'b0;
      pend_wave <= 16'h0000;
      pend_chan <= 8'h00;
      pend_rate <= 4'h0;
      playing <= 1'b0;
      play_start <= 1'b0;
      play_wave_id <= 16'h0000;
      play_channels <= 8'h00;
      play_rate <= 4'h0;
      port_oe_n <= 1'b1;
    end else begin
      pend <= next_pend;
      pend_wave <= next_pend_wave;
      pend_chan <= next_pend_chan;
      pend_rate <= next_pend_rate;
      playing <= next_playing;
      play_start <= next_play_start;
      play_wave_id <= next_play_wave_id;
      play_channels <= next_play_channels;
      play_rate <= next_play_rate;
      port_oe_n <= !cfg_port_drive;
    end
  end

endmodule : spio_exec
`default_nettype wire

//--- spio_exec_monitor.sv
/* Checker for spio_exec: timing relations at its ports.
   Assumes one clock domain; bound to the design at the foot of this file. */
`timescale 1ns/10ps
`default_nettype none
module spio_exec_monitor
  import spio_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire spio_op_t instr_op,
  input wire logic [31:0] instr_value,
  input wire logic result_valid,
  input wire logic [31:0] result_data,
  input wire logic [31:0] port_in,
  input wire logic [31:0] port_out,
  input wire logic [3:0] trig_out,
  input wire logic [31:0] stream_index,
  input wire logic sync_req,
  input wire logic sync_ack,
  input wire logic node_wr_valid,
  input wire logic node_wr_ready,
  input wire logic [31:0] node_data
);
  logic take;
  assign take = instr_valid && instr_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  pace_hold_a: assert property ($changed(port_out) |=> $stable(port_out))
    else $error("port word changed on two edges running");
  live_read_a: assert property (take && instr_op == OP_PORT_READ |=>
    result_valid && result_data == $past(port_in)) else $error("live read wrong");
  trig_write_a: assert property (take && instr_op == OP_TRIG_OUT |=>
    trig_out == $past(instr_value[3:0])) else $error("trigger lines wrong");
  delay_zero_a: assert property (take && instr_op == OP_DELAY && instr_value == 0 |=>
    !instr_ready ##1 !instr_ready ##1 instr_ready) else $error("delay zero spacing wrong");
  index_load_a: assert property (take && instr_op inside {OP_INDEX_SET, OP_INDEX_ALIAS} |=>
    stream_index == $past(instr_value)) else $error("stream index not loaded");
  read_cause_a: assert property (result_valid |-> $past(take) &&
    $past(instr_op) inside {OP_PORT_READ, OP_PORT_LATCHED_READ, OP_TRIG_IN_READ})
    else $error("result without a read");
  node_hold_a: assert property (node_wr_valid && !node_wr_ready |=>
    node_wr_valid && $stable(node_data)) else $error("node write dropped");
  sync_hold_a: assert property (sync_req && !sync_ack |=> sync_req)
    else $error("sync request dropped");
endmodule : spio_exec_monitor

bind spio_exec spio_exec_monitor u_spio_exec_monitor (.clk, .rstn, .instr_valid, .instr_ready,
  .instr_op, .instr_value, .result_valid, .result_data, .port_in, .port_out, .trig_out,
  .stream_index, .sync_req, .sync_ack, .node_wr_valid, .node_wr_ready, .node_data);
`default_nettype wire

//--- spio_ext_model.sv
/* Far-side equipment on the parallel port and trigger inputs.
   Assumes the bench sets its words at clock edges. */
`timescale 1ns/10ps
`default_nettype none
module spio_ext_model (
  input wire logic [31:0] port_out,
  input wire logic port_oe_n,
  output logic [31:0] port_in,
  output logic [7:0] trig_in,
  output logic [7:0] trig_alt
);
  logic [31:0] word;
  logic [7:0] tin;
  logic [7:0] talt;
  initial begin
    word = 32'h00000000;
    tin = 8'h00;
    talt = 8'h00;
  end
  // The wire shows the block's word only while the block drives it.
  assign port_in = port_oe_n ? word : port_out;
  assign trig_in = tin;
  assign trig_alt = talt;
  task automatic set_word(input logic [31:0] w);
    word <= w;
  endtask : set_word
  task automatic set_trig(input logic [7:0] a, input logic [7:0] b);
    tin <= a;
    talt <= b;
  endtask : set_trig
endmodule : spio_ext_model
`default_nettype wire

//--- testbench.sv
/* Self-checking bench for spio_exec.
   Assumes the checker binds itself and the far-side model is spio_ext_model. */
`timescale 1ns/10ps
`default_nettype none
module testbench
  import spio_pkg::*;
;
  logic clk, rstn, instr_valid, instr_ready, result_valid, port_oe_n, cfg_port_drive;
  logic play_start, wave_done, cfg_sync_linked, sync_req, sync_ack, node_wr_valid, node_wr_ready;
  spio_op_t instr_op;
  logic [31:0] instr_value, instr_arg, instr_scale, result_data, port_in, port_out, stream_index, node_data;
  logic [7:0] instr_sel, trig_in, trig_alt, cfg_trig_src, play_channels, self_device, node_dev;
  logic [4:0] cfg_strobe_idx;
  logic [1:0] cfg_strobe_slope;
  logic [3:0] trig_out, default_sample_rate, play_rate;
  logic [15:0] play_wave_id, node_addr;
  int error_cnt, checks, cyc;
  spio_exec u_spio_exec (.clk, .rstn, .instr_valid, .instr_ready, .instr_op, .instr_value, .instr_arg,
    .instr_scale, .instr_sel, .result_valid, .result_data, .port_in, .port_out, .port_oe_n,
    .cfg_port_drive, .cfg_strobe_idx, .cfg_strobe_slope, .trig_out, .trig_in, .trig_alt,
    .cfg_trig_src, .stream_index, .default_sample_rate, .play_start, .play_wave_id, .play_channels,
    .play_rate, .wave_done, .cfg_sync_linked, .sync_req, .sync_ack, .self_device, .node_wr_valid,
    .node_wr_ready, .node_dev, .node_addr, .node_data);
  spio_ext_model u_spio_ext_model (.port_out, .port_oe_n, .port_in, .trig_in, .trig_alt);
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 100 && s !== 1'b1; i++) @(posedge clk);
    // A handshake that never completes is a mismatch, so a hang cannot slip through.
    if (s !== 1'b1) begin
      error_cnt++;
      $display("ERROR handshake wait expected 1 seen %b", s);
    end
  endtask : wait_hi
  // The request is held from one edge until the edge that sees ready high.
  task automatic issue(input spio_op_t op, input logic [31:0] v, input logic [31:0] a, input logic [7:0] s,
                       output int t);
    @(posedge clk);
    instr_op <= op;
    instr_value <= v;
    instr_arg <= a;
    instr_sel <= s;
    instr_valid <= 1'b1;
    @(posedge clk);
    wait_hi(instr_ready);
    t = cyc;
    instr_valid <= 1'b0;
  endtask : issue
  task automatic pulse_done();
    wave_done <= 1'b1;
    @(posedge clk);
    wave_done <= 1'b0;
  endtask : pulse_done
  ////////////////////////////////////////////////////////////
  task automatic t_port();
    int t;
    @(posedge clk);
    cfg_port_drive <= 1'b1;
    issue(OP_PORT_WRITE, 32'hA5C30F1E, 32'h0, 8'h00, t);
    issue(OP_PORT_WRITE, 32'h5A3CF0E1, 32'h0, 8'h00, t);
    #1 chk("port_out", 32'hA5C30F1E, port_out);
    chk("port_oe_n", 32'h0, 32'(port_oe_n));
    repeat (3) @(posedge clk);
    #1 chk("port_out", 32'h5A3CF0E1, port_out);
    @(posedge clk);
    cfg_port_drive <= 1'b0;
    u_spio_ext_model.set_word(32'h13579BDF);
    issue(OP_PORT_READ, 32'h0, 32'h0, 8'h00, t);
    #1 chk("live read", 32'h13579BDF, result_data);
    chk("port release", 32'h1, 32'(port_oe_n));
  endtask : t_port
  task automatic t_strobe();
    int t;
    @(posedge clk);
    cfg_strobe_idx <= 5'h03;
    cfg_strobe_slope <= SLOPE_RISE;
    u_spio_ext_model.set_word(32'h000000F0);
    issue(OP_STROBE_WAIT, 32'h0, 32'h0, 8'h00, t);
    repeat (4) @(posedge clk);
    chk("wait held", 32'h0, 32'(instr_ready));
    u_spio_ext_model.set_word(32'hCAFE0008);
    wait_hi(instr_ready);
    chk("wait released", 32'h1, 32'(instr_ready));
    u_spio_ext_model.set_word(32'h00000001);
    issue(OP_PORT_LATCHED_READ, 32'h0, 32'h0, 8'h00, t);
    #1 chk("latched read", 32'hCAFE0008, result_data);
    // The rising edge below must be ignored under falling polarity; only the fall latches.
    @(posedge clk);
    cfg_strobe_slope <= SLOPE_FALL;
    u_spio_ext_model.set_word(32'h0000000F);
    issue(OP_STROBE_WAIT, 32'h0, 32'h0, 8'h00, t);
    u_spio_ext_model.set_word(32'hBEEF0000);
    issue(OP_PORT_LATCHED_READ, 32'h0, 32'h0, 8'h00, t);
    #1 chk("falling strobe latch", 32'hBEEF0000, result_data);
  endtask : t_strobe
  task automatic t_trig();
    int t;
    logic e;
    for (int i = 0; i < 16; i++) begin
      issue(OP_TRIG_OUT, 32'(i), 32'h0, 8'h00, t);
      #1 chk("trig_out", 32'(i), 32'(trig_out));
    end
    @(posedge clk);
    u_spio_ext_model.set_trig(8'hA5, 8'h3C);
    cfg_trig_src <= 8'hF0;
    for (int k = 0; k < 10; k++) begin
      e = (k >= 1 && k <= 8) ? (8'hF0 >> (k - 1)) & 1 ? 8'h3C >> (k - 1) : 8'hA5 >> (k - 1) : 1'b0;
      issue(OP_TRIG_IN_READ, 32'h0, 32'h0, 8'(k), t);
      #1 chk("trigger input", 32'(e), result_data);
    end
  endtask : t_trig
  task automatic t_delay_index();
    int t0;
    int t1;
    for (int n = 0; n < 8; n += 7) begin
      issue(OP_DELAY, 32'(n), 32'h0, 8'h00, t0);
      issue(OP_NOP, 32'h0, 32'h0, 8'h00, t1);
      chk("delay spacing", 32'(n + 3), 32'(t1 - t0));
    end
    issue(OP_INDEX_SET, 32'h0000BEEF, 32'h0, 8'h00, t0);
    #1 chk("index", 32'h0000BEEF, stream_index);
    issue(OP_INDEX_ALIAS, 32'h12345678, 32'h0, 8'h00, t0);
    #1 chk("index alias", 32'h12345678, stream_index);
  endtask : t_delay_index
  task automatic t_play();
    int t;
    @(posedge clk);
    default_sample_rate <= 4'h6;
    // Wave ids name reserved slots whose samples the host loads after the program.
    issue(OP_PLAY, 32'h00000011, 32'h00000003, 8'h00, t);
    wait_hi(play_start);
    chk("auto channels", 32'h07, 32'(play_channels));
    chk("default rate", 32'h6, 32'(play_rate));
    issue(OP_PLAY, 32'h00000022, 32'h00000191, 8'h30, t);
    repeat (3) @(posedge clk);
    chk("queued start", 32'h0, 32'(play_start));
    pulse_done();
    #1 chk("gapless start", 32'h1, 32'(play_start));
    chk("wave id", 32'h22, 32'(play_wave_id));
    chk("given rate", 32'h9, 32'(play_rate));
    chk("given channels", 32'h30, 32'(play_channels));
    issue(OP_PLAY_DONE_WAIT, 32'h0, 32'h0, 8'h00, t);
    repeat (3) @(posedge clk);
    chk("playback wait", 32'h0, 32'(instr_ready));
    pulse_done();
    wait_hi(instr_ready);
    chk("playback done", 32'h1, 32'(instr_ready));
  endtask : t_play
  task automatic t_node(input spio_op_t op, input logic [31:0] v, input logic [31:0] a, input logic [31:0] sc,
                        input logic [7:0] dv, input logic [31:0] d);
    int t;
    @(posedge clk);
    instr_scale <= sc;
    issue(op, v, a, 8'h00, t);
    wait_hi(node_wr_valid);
    chk("node dev", 32'(dv), 32'(node_dev));
    chk("node addr", 32'(a[15:0]), 32'(node_addr));
    chk("node data", d, node_data);
    repeat (2) @(posedge clk);
    chk("node held", 32'h1, 32'(node_wr_valid));
    node_wr_ready <= 1'b1;
    @(posedge clk);
    node_wr_ready <= 1'b0;
    wait_hi(instr_ready);
  endtask : t_node
  task automatic t_sync();
    int t;
    @(posedge clk);
    cfg_sync_linked <= 1'b1;
    issue(OP_SYNC, 32'h0, 32'h0, 8'h00, t);
    wait_hi(sync_req);
    repeat (2) @(posedge clk);
    chk("sync held", 32'h1, 32'(sync_req));
    sync_ack <= 1'b1;
    @(posedge clk);
    sync_ack <= 1'b0;
    wait_hi(instr_ready);
    chk("sync done", 32'h1, 32'(instr_ready));
  endtask : t_sync
  task automatic print_verdict();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////
  initial begin
    {rstn, instr_valid, cfg_port_drive, wave_done, cfg_sync_linked, sync_ack, node_wr_ready} = '0;
    {instr_value, instr_arg, instr_scale, instr_sel, cfg_trig_src} = '0;
    {cfg_strobe_idx, cfg_strobe_slope, default_sample_rate} = '0;
    instr_op = OP_NOP;
    self_device = 8'h5A;
    {error_cnt, checks} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_port();
    t_strobe();
    t_trig();
    t_delay_index();
    t_play();
    t_node(OP_NODE_INT, 32'h00001234, 32'h00000042, 32'h0, 8'h5A, 32'h00001234);
    t_node(OP_NODE_FLOAT, 32'hFFFFFFFE, 32'h00210007, 32'h0, 8'h21, 32'hFFFFFFFE);
    t_node(OP_NODE_FLOAT_SCALED, 32'h4, 32'h00210007, 32'h00028000, 8'h21, 32'h0000000A);
    t_sync();
    print_verdict();
  end
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
